/* File: smb1_far_model.sv */
// Far-side model of the second mailbox: delivers and consumes whole message words.
`timescale 1ns/1ps
module smb1_far_model
  import smb1_pkg::*;
(
  input wire logic sys_clk_i,
  output logic remote_load_o,
  output logic [31:0] remote_data_o,
  output logic remote_take_o
);
  // Quiet start; the idle data word is a pattern that never matches a sent message.
  initial begin
    remote_load_o = 1'b0;
    remote_data_o = 32'h5A5AA5A5;
    remote_take_o = 1'b0;
  end

  // One-cycle delivery pulse, word beside it; afterwards the word is inverted so stale data
  // can never pass for a valid message.
  task automatic send(input logic [31:0] word);
    @(posedge sys_clk_i);
    remote_load_o <= 1'b1;
    remote_data_o <= word;
    @(posedge sys_clk_i);
    remote_load_o <= 1'b0;
    remote_data_o <= ~word;
  endtask

  // One-cycle consume pulse, as the far side does once it has read the message.
  task automatic take_msg();
    @(posedge sys_clk_i);
    remote_take_o <= 1'b1;
    @(posedge sys_clk_i);
    remote_take_o <= 1'b0;
  endtask
endmodule

/* File: smb1_mailbox.sv */
// Second message mailbox of a subordinate node: control, status, four data bytes, interrupt.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module smb1_mailbox
  import smb1_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic subordinate_mode_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic remote_load_i,
  input wire logic [31:0] remote_data_i,
  input wire logic remote_take_i,
  output logic [31:0] remote_data_o,
  output logic remote_full_o,
  output logic irq_o
);

  // Address match, used for every register decode.
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offs);
    addr_hit = (addr == offs);
  endfunction

  smb1_req_type req;
  smb1_state_type state_r;
  smb1_state_type state_nxt;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic eirq_r;
  logic eirq_nxt;
  logic firq_r;
  logic firq_nxt;
  logic irq_r;
  logic full_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [31:0] msg;
  logic [3:0] byte_hit;
  logic [3:0] byte_we;
  logic [7:0] byte_sel;

  // Bundle the local access.
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // The whole map is hidden outside subordinate mode, so a main node sees zeros there.
  wire sub_en = subordinate_mode_i;
  wire ctl_hit = sub_en & addr_hit(req.addr, SMB1_CTL_OFFS);
  wire stat_hit = sub_en & addr_hit(req.addr, SMB1_STAT_OFFS);
  wire itype_hit = sub_en & addr_hit(req.addr, SMB1_ITYPE_OFFS);
  wire wr_ctl = req.wr & ctl_hit;
  wire wr_itype = req.wr & itype_hit;

  // Data byte decode, one lane per byte of the message.
  genvar g;
  generate
    for (g = 0; g < SMB1_MSG_BYTES; g++) begin : g_byte
      assign byte_hit[g] = sub_en & addr_hit(req.addr, SMB1_BYTE0_OFFS + 8'(g));
      assign byte_we[g] = req.wr & byte_hit[g];
    end
  endgenerate

  // Control fields.
  wire mbox_en = ctl_r[SMB1_CTL_EN_BIT];
  wire dir_tx = ctl_r[SMB1_CTL_DIR_BIT];
  wire eien = ctl_r[SMB1_CTL_EIEN_BIT];
  wire fien = ctl_r[SMB1_CTL_FIEN_BIT];
  wire [1:0] len_sel = ctl_r[SMB1_CTL_LEN_MSB:SMB1_CTL_LEN_LSB];
  wire is_empty = (state_r == SMB1_ST_EMPTY);
  wire is_full = (state_r == SMB1_ST_FULL);

  // The last byte of the configured length completes or consumes the message.
  wire last_wr = byte_we[len_sel];
  wire last_rd = req.rd & byte_hit[len_sel];
  wire go_full = mbox_en & is_empty & (dir_tx ? last_wr : remote_load_i);
  wire go_empty = mbox_en & is_full & (dir_tx ? remote_take_i : last_rd);
  wire rx_load = go_full & ~dir_tx;

  // Occupancy; a disabled mailbox is held empty and raises nothing.
  always_comb begin
    state_nxt = state_r;
    if (!mbox_en) begin
      state_nxt = SMB1_ST_EMPTY;
    end else begin
      case (state_r)
        SMB1_ST_EMPTY: begin
          if (go_full) begin
            state_nxt = SMB1_ST_FULL;
          end
        end
        SMB1_ST_FULL: begin
          if (go_empty) begin
            state_nxt = SMB1_ST_EMPTY;
          end
        end
        default: begin
          state_nxt = SMB1_ST_EMPTY;
        end
      endcase
    end
  end

  // Interrupt flags: a new event beats a write-one clear in the same cycle.
  wire eirq_set = go_empty & eien;
  wire firq_set = go_full & fien;
  wire eirq_clr = wr_itype & req.wdata[SMB1_STAT_EIRQ_BIT];
  wire firq_clr = wr_itype & req.wdata[SMB1_STAT_FIRQ_BIT];
  assign eirq_nxt = eirq_set | (eirq_r & ~eirq_clr);
  assign firq_nxt = firq_set | (firq_r & ~firq_clr);

  // Control register; the status register has no write path at all.
  assign ctl_nxt = wr_ctl ? (req.wdata & SMB1_CTL_MASK) : ctl_r;

  // Read-back words; interrupt type repeats the two status flag bits and reads zero in bits 3:0.
  wire [7:0] stat_word = {2'b00, eirq_r, firq_r, 2'b00, is_empty, is_full};
  wire [7:0] itype_word = {2'b00, eirq_r, firq_r, 4'h0};
  assign byte_sel = (byte_hit[0] ? msg[7:0] : SMB1_ZERO_BYTE) |
                    (byte_hit[1] ? msg[15:8] : SMB1_ZERO_BYTE) |
                    (byte_hit[2] ? msg[23:16] : SMB1_ZERO_BYTE) |
                    (byte_hit[3] ? msg[31:24] : SMB1_ZERO_BYTE);
  wire [7:0] rd_mux = (ctl_hit ? ctl_r : SMB1_ZERO_BYTE) |
                      (stat_hit ? stat_word : SMB1_ZERO_BYTE) |
                      (itype_hit ? itype_word : SMB1_ZERO_BYTE) |
                      byte_sel;
  // Read data stand only in the cycle after the strobe; unmapped reads give zero.
  assign rdata_nxt = req.rd ? rd_mux : SMB1_ZERO_BYTE;

  // Message bytes live in the store; a receive load overwrites all four.
  smb1_msg_store u_store (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .byte_we_i(byte_we),
    .byte_wdata_i(req.wdata),
    .load_i(rx_load),
    .load_data_i(remote_data_i),
    .msg_o(msg)
  );

  // State, flags and output registers.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_r <= SMB1_ST_EMPTY;
      ctl_r <= SMB1_CTL_RST;
      eirq_r <= 1'b0;
      firq_r <= 1'b0;
      irq_r <= 1'b0;
      full_r <= 1'b0;
      rdata_r <= SMB1_ZERO_BYTE;
    end else begin
      state_r <= state_nxt;
      ctl_r <= ctl_nxt;
      eirq_r <= eirq_nxt;
      firq_r <= firq_nxt;
      irq_r <= eirq_nxt | firq_nxt;
      full_r <= (state_nxt == SMB1_ST_FULL);
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign remote_data_o = msg;
  assign remote_full_o = full_r;
  assign irq_o = irq_r;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_MAIN_HIDDEN: assert property (
    (req.rd && !subordinate_mode_i) |=> (reg_rdata_o == 8'h00))
    else $error("Mailbox map visible outside subordinate mode.");

  AST_STAT_RO: assert property (
    (req.wr && stat_hit && !go_full && !go_empty && !eirq_clr && !firq_clr && mbox_en
     && !eirq_set && !firq_set && !wr_ctl) |=> $stable(stat_word))
    else $error("Status changed on a software write.");

  AST_EIRQ_BIT: assert property (
    (req.rd && stat_hit) |=> (reg_rdata_o[5] == $past(eirq_r)))
    else $error("Status bit 5 does not show the empty interrupt.");

  AST_FIRQ_BIT: assert property (
    (req.rd && stat_hit) |=> (reg_rdata_o[4] == $past(firq_r)))
    else $error("Status bit 4 does not show the full interrupt.");

  AST_EMPTY_BIT: assert property (
    (req.rd && stat_hit) |=> (reg_rdata_o[1] == $past(is_empty)))
    else $error("Status bit 1 does not show empty.");

  AST_FULL_BIT: assert property (
    (req.rd && stat_hit)
      |=> (reg_rdata_o[0] == $past(is_full) && reg_rdata_o[0] == $past(remote_full_o)))
    else $error("Status bit 0 does not show full.");

  AST_BYTE0_RW: assert property (
    (byte_we[0] && !rx_load) ##1 (!rx_load && !byte_we[0]) ##1 (req.rd && byte_hit[0])
      |=> (reg_rdata_o == $past(req.wdata, 3)))
    else $error("Byte 0 does not read back.");

  AST_BYTE1_RW: assert property (
    (byte_we[1] && !rx_load) |=> (remote_data_o[15:8] == $past(req.wdata)))
    else $error("Byte 1 does not land in message bits 15:8.");

  AST_BYTE2_RW: assert property (
    (byte_we[2] && !rx_load) |=> (remote_data_o[23:16] == $past(req.wdata)))
    else $error("Byte 2 does not land in message bits 23:16.");

  AST_BYTE3_RW: assert property (
    (byte_we[3] && !rx_load) ##1 (!rx_load && !byte_we[3]) ##1 (req.rd && byte_hit[3])
      |=> (reg_rdata_o == $past(req.wdata, 3)))
    else $error("Byte 3 does not read back.");

  AST_IRQ_PIN: assert property (
    (eirq_r || firq_r) |-> irq_o)
    else $error("Pending interrupt not on the request pin.");

  AST_LEN_FILL: assert property (
    (mbox_en && dir_tx && is_empty && byte_we[len_sel]) |=> is_full [*1] ##0 remote_full_o)
    else $error("Last byte of the configured length did not fill the mailbox.");

  AST_SHORT_WRITE: assert property (
    (mbox_en && dir_tx && is_empty && |byte_we && !byte_we[len_sel]) |=> is_empty)
    else $error("A byte below the configured length filled the mailbox.");

  AST_RX_LOAD: assert property (
    (mbox_en && !dir_tx && is_empty && remote_load_i) |=> (is_full && msg == $past(remote_data_i)))
    else $error("Receive load did not fill the mailbox.");

  AST_FIRQ_GATE: assert property (
    (go_full && !fien && !firq_r) |=> !firq_r)
    else $error("Full interrupt raised while disabled.");

  AST_EIRQ_GATE: assert property (
    (go_empty && eien) |=> (eirq_r && irq_o))
    else $error("Enabled empty interrupt not raised.");

  AST_ONE_STATE: assert property (
    (is_full != is_empty) and (!mbox_en |=> is_empty))
    else $error("Mailbox occupancy inconsistent.");

  // Checks on refusals, emptying, flag set and clear, unused bits and the idle read port; software relies on zeros here.
  AST_RDATA_IDLE: assert property (
    !req.rd |=> (reg_rdata_o == 8'h00))
    else $error("Read data not zero outside the answer cycle.");

  AST_HIDDEN_WRITE: assert property (
    (req.wr && !subordinate_mode_i && !rx_load)
      |=> (ctl_r == $past(ctl_r) && msg == $past(msg)))
    else $error("Write landed outside subordinate mode.");

  AST_CTL_TOP_ZERO: assert property (
    (req.rd && ctl_hit) |=> (reg_rdata_o[7:6] == 2'b00))
    else $error("Unused control bits read back nonzero.");

  AST_RX_EMPTIES: assert property (
    (mbox_en && !dir_tx && is_full && req.rd && byte_hit[len_sel]) |=> is_empty)
    else $error("Reading the last received byte did not empty the mailbox.");

  AST_TX_EMPTIES: assert property (
    (mbox_en && dir_tx && is_full && remote_take_i) |=> (is_empty && !remote_full_o))
    else $error("Far-side take did not empty the transmit mailbox.");

  AST_LOAD_REFUSED: assert property (
    (remote_load_i && is_full && !(|byte_we)) |=> (msg == $past(msg)))
    else $error("A load into a full mailbox changed the message.");

  AST_FFLAG_CLEAR: assert property (
    (wr_itype && req.wdata[SMB1_STAT_FIRQ_BIT] && !firq_set) |=> !firq_r)
    else $error("Full interrupt flag not cleared by a write of one.");

  AST_EFLAG_CLEAR: assert property (
    (wr_itype && req.wdata[SMB1_STAT_EIRQ_BIT] && !eirq_set) |=> !eirq_r)
    else $error("Empty interrupt flag not cleared by a write of one.");

  AST_FIRQ_ON: assert property (
    (go_full && fien) |=> (firq_r && irq_o))
    else $error("Enabled full interrupt not raised.");

  AST_EIRQ_OFF: assert property (
    (go_empty && !eien && !eirq_r) |=> !eirq_r)
    else $error("Empty interrupt raised while disabled.");

  COV_TX_ROUND: cover property (go_full && dir_tx ##[1:60] go_empty);
  COV_REFUSED_LOAD: cover property (remote_load_i && is_full);
  COV_RX_ROUND: cover property (rx_load ##[1:20] last_rd && is_full);
  COV_SET_CLEAR: cover property (eirq_set && eirq_clr);
  COV_IRQ: cover property (firq_set ##1 irq_o);

endmodule

/* File: smb1_mailbox_tb_top.sv */
// Self-checking testbench of the second message mailbox.
`timescale 1ns/1ps
module smb1_mailbox_tb_top;
  import smb1_pkg::*;
  logic sys_clk_i;
  logic sys_rst_i;
  logic sub_mode;
  smb1_req_type req;
  logic [7:0] rdata;
  logic load;
  logic [31:0] ldata;
  logic take;
  logic [31:0] mdata;
  logic mfull;
  logic irq;
  int n_mismatch;
  int samples_checked;
  logic [31:0] seed;
  logic [31:0] word;
  logic [7:0] rb;

  smb1_mailbox u_dut (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .subordinate_mode_i(sub_mode),
    .reg_addr_i(req.addr),
    .reg_wdata_i(req.wdata),
    .reg_wr_i(req.wr),
    .reg_rd_i(req.rd),
    .reg_rdata_o(rdata),
    .remote_load_i(load),
    .remote_data_i(ldata),
    .remote_take_i(take),
    .remote_data_o(mdata),
    .remote_full_o(mfull),
    .irq_o(irq)
  );

  smb1_far_model u_far (
    .sys_clk_i(sys_clk_i),
    .remote_load_o(load),
    .remote_data_o(ldata),
    .remote_take_o(take)
  );

  // Free-running 20 MHz clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // Repeatable pseudo-random words; a shift register keeps the run identical on every tool.
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] stat(input logic ei, input logic fi, input logic em,
                                      input logic fu);
    stat = {2'h0, ei, fi, 2'h0, em, fu};
  endfunction
  function automatic logic [7:0] lane(input logic [31:0] w, input int i);
    lane = w[8*i +: 8];
  endfunction

  // Bus cycles always start one edge later, so a strobe is never assigned twice in one step.
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
    #1;
    rb = rdata;
    chk_byte(rb, exp);
  endtask

  // Comparisons, one per kind of result.
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    n_mismatch++;
    results();
  end

  // Main sequence: transmit, receive at every length, hidden map, unmapped address.
  initial begin
    sys_rst_i = 1'b1;
    sub_mode = 1'b1;
    req = '0;
    n_mismatch = 0;
    samples_checked = 0;
    seed = 32'h338C;
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd_chk(SMB1_STAT_OFFS, stat(1'b0, 1'b0, 1'b1, 1'b0));
    chk_bit(irq, 1'b0);
    bus_wr(SMB1_CTL_OFFS, 8'h3B);
    rd_chk(SMB1_CTL_OFFS, 8'h3B);
    seed = lfsr(seed);
    word = seed;
    for (int i = 0; i < 4; i++) begin
      rd_chk(SMB1_STAT_OFFS, stat(1'b0, 1'b0, 1'b1, 1'b0));
      bus_wr(SMB1_BYTE0_OFFS + 8'(i), lane(word, i));
      rd_chk(SMB1_BYTE0_OFFS + 8'(i), lane(word, i));
    end
    rd_chk(SMB1_STAT_OFFS, stat(1'b0, 1'b1, 1'b0, 1'b1));
    chk_bit(mfull, 1'b1);
    chk_bit(irq, 1'b1);
    chk_word(mdata, word);
    for (int i = 0; i < 4; i++) begin
      rd_chk(SMB1_BYTE0_OFFS + 8'(i), lane(word, i));
    end
    bus_wr(SMB1_STAT_OFFS, 8'hFF);
    rd_chk(SMB1_STAT_OFFS, stat(1'b0, 1'b1, 1'b0, 1'b1));
    rd_chk(SMB1_ITYPE_OFFS, 8'h10);
    u_far.take_msg();
    rd_chk(SMB1_STAT_OFFS, stat(1'b0, 1'b1, 1'b1, 1'b0));
    bus_wr(SMB1_ITYPE_OFFS, 8'h10);
    rd_chk(SMB1_STAT_OFFS, stat(1'b0, 1'b0, 1'b1, 1'b0));
    chk_bit(irq, 1'b0);
    u_far.send(~word);
    rd_chk(SMB1_STAT_OFFS, stat(1'b0, 1'b0, 1'b1, 1'b0));
    // Receive direction at each length; the second load is refused because the box is full.
    for (int len = 0; len < 4; len++) begin
      bus_wr(SMB1_CTL_OFFS, {2'h0, 2'(len), 4'h5});
      seed = lfsr(seed);
      word = seed;
      u_far.send(word);
      seed = lfsr(seed);
      u_far.send(seed);
      for (int i = 0; i <= len; i++) begin
        rd_chk(SMB1_STAT_OFFS, stat(1'b0, 1'b0, 1'b0, 1'b1));
        rd_chk(SMB1_BYTE0_OFFS + 8'(i), lane(word, i));
      end
      chk_word(mdata, word);
      rd_chk(SMB1_STAT_OFFS, stat(1'b1, 1'b0, 1'b1, 1'b0));
      chk_bit(irq, 1'b1);
      bus_wr(SMB1_ITYPE_OFFS, 8'h20);
    end
    // With the node not subordinate the map is hidden and writes are dropped.
    sub_mode <= 1'b0;
    bus_wr(SMB1_BYTE0_OFFS, ~lane(word, 0));
    rd_chk(SMB1_STAT_OFFS, 8'h00);
    @(posedge sys_clk_i);
    sub_mode <= 1'b1;
    rd_chk(SMB1_BYTE0_OFFS, lane(word, 0));
    rd_chk(8'h9D, 8'h00);
    results();
  end
endmodule

/* File: smb1_msg_store.sv */
// Four-byte message store with per-byte local writes and a whole-word load from the far side.
`timescale 1ns/1ps
module smb1_msg_store
  import smb1_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] byte_we_i,
  input wire logic [7:0] byte_wdata_i,
  input wire logic load_i,
  input wire logic [31:0] load_data_i,
  output logic [31:0] msg_o
);

  logic [31:0] msg_r;
  logic [31:0] msg_nxt;

  // Each byte lane takes the whole-word load first; the far side owns a full message.
  genvar g;
  generate
    for (g = 0; g < SMB1_MSG_BYTES; g++) begin : g_lane
      assign msg_nxt[g*8 +: 8] = load_i ? load_data_i[g*8 +: 8] :
                                 byte_we_i[g] ? byte_wdata_i : msg_r[g*8 +: 8];
    end
  endgenerate

  // Message word register; the outputs read it directly.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      msg_r <= SMB1_MSG_RST;
    end else begin
      msg_r <= msg_nxt;
    end
  end

  assign msg_o = msg_r;

endmodule

/* File: smb1_pkg.sv */
// Package with offsets, field positions, reset values and types of the second message mailbox.
package smb1_pkg;

  // Register offsets on the local register port.
  localparam logic [7:0] SMB1_CTL_OFFS = 8'h96;
  localparam logic [7:0] SMB1_STAT_OFFS = 8'h97;
  localparam logic [7:0] SMB1_BYTE0_OFFS = 8'h98;
  localparam logic [7:0] SMB1_BYTE1_OFFS = 8'h99;
  localparam logic [7:0] SMB1_BYTE2_OFFS = 8'h9A;
  localparam logic [7:0] SMB1_BYTE3_OFFS = 8'h9B;
  localparam logic [7:0] SMB1_ITYPE_OFFS = 8'h9C;

  // Widths.
  localparam int SMB1_DATA_W = 8;
  localparam int SMB1_MSG_BYTES = 4;
  localparam int SMB1_MSG_W = 32;

  // Control field positions.
  localparam int SMB1_CTL_EN_BIT = 0;
  localparam int SMB1_CTL_DIR_BIT = 1;
  localparam int SMB1_CTL_EIEN_BIT = 2;
  localparam int SMB1_CTL_FIEN_BIT = 3;
  localparam int SMB1_CTL_LEN_LSB = 4;
  localparam int SMB1_CTL_LEN_MSB = 5;
  localparam logic [7:0] SMB1_CTL_MASK = 8'h3F;

  // Status and interrupt-type field positions.
  localparam int SMB1_STAT_EIRQ_BIT = 5;
  localparam int SMB1_STAT_FIRQ_BIT = 4;
  localparam int SMB1_STAT_EMPTY_BIT = 1;
  localparam int SMB1_STAT_FULL_BIT = 0;

  // Values after reset.
  localparam logic [7:0] SMB1_CTL_RST = 8'h00;
  localparam logic [7:0] SMB1_ZERO_BYTE = 8'h00;
  localparam logic [31:0] SMB1_MSG_RST = 32'h00000000;

  // Occupancy of the mailbox, one-hot.
  typedef enum logic [1:0] {
    SMB1_ST_EMPTY = 2'b01,
    SMB1_ST_FULL = 2'b10
  } smb1_state_type;

  // One access on the local register port.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } smb1_req_type;

endpackage
